/* src/cppc_pkg.sv */
// constants shared by the cluster power control port ends
//------------------------------------------------------------------------------
// Operation
// - controller drives one interrupt clamp per core
// - controller asserts ram clamps during dormant mode
// - simd clamp 0 inactive, 1 active
// - core0 status bits 1:0 load at reset
// - core1 status bits 9:8 load at reset
// - core2 status bits 17:16 load at reset
// - core3 status bits 25:24 load at reset
// - request b0x means keep core powered
// - request b10 allows dormant mode
// - request b11 allows power off
// - requests exist only for present cores; here absent cores still drive b00 on their request pins
// - idle may halt level-2 cache clock
//------------------------------------------------------------------------------
package cppc_pkg;
  localparam int          CPPC_MAX_CORES    = 4;
  localparam int          CPPC_FIELD_W      = 2;
  localparam int          CPPC_FIELD_STRIDE = 8;
  localparam int          CPPC_STATUS_W     = 32;
  // power request encodings
  localparam logic [1:0]  CPPC_REQ_ON       = 2'h0;
  localparam logic [1:0]  CPPC_REQ_DORMANT  = 2'h2;
  localparam logic [1:0]  CPPC_REQ_OFF      = 2'h3;
  localparam int          CPPC_REQ_OFF_BIT  = 1;
  // own registers of the external controller, apb byte offsets
  localparam logic [11:0] CPPC_CTRL_OFF     = 12'h000;
  localparam logic [11:0] CPPC_STAT_OFF     = 12'h004;
  localparam logic [11:0] CPPC_INIT_OFF     = 12'h008;
  localparam logic [31:0] CPPC_ZERO_WORD    = 32'h0000_0000;
  // ctrl field positions
  localparam int          CPPC_CTRL_IFC_LSB = 0;
  localparam int          CPPC_CTRL_RAM_LSB = 4;
  localparam int          CPPC_CTRL_SIMD_LSB = 8;
  localparam int          CPPC_CTRL_COH_BIT = 12;
  // stat field positions
  localparam int          CPPC_STAT_IDLE_BIT = 16;
endpackage : cppc_pkg

/* src/cppc_if.sv */
// pin bundle between the cluster and its external power controller
interface cppc_if;
  import cppc_pkg::*;
  logic [CPPC_MAX_CORES-1:0] interrupt_iface_clamp;
  logic [CPPC_MAX_CORES-1:0] core_ram_clamp;
  logic                      coherency_ram_clamp;
  logic [CPPC_MAX_CORES-1:0] simd_logic_clamp;
  logic [1:0]                power_status_init_core0;
  logic [1:0]                power_status_init_core1;
  logic [1:0]                power_status_init_core2;
  logic [1:0]                power_status_init_core3;
  logic [1:0]                power_request_core0;
  logic [1:0]                power_request_core1;
  logic [1:0]                power_request_core2;
  logic [1:0]                power_request_core3;
  logic                      coherency_unit_idle;

  modport cluster (
    input  interrupt_iface_clamp, core_ram_clamp, coherency_ram_clamp, simd_logic_clamp,
    input  power_status_init_core0, power_status_init_core1,
    input  power_status_init_core2, power_status_init_core3,
    output power_request_core0, power_request_core1, power_request_core2, power_request_core3,
    output coherency_unit_idle
  );
  modport controller (
    output interrupt_iface_clamp, core_ram_clamp, coherency_ram_clamp, simd_logic_clamp,
    output power_status_init_core0, power_status_init_core1,
    output power_status_init_core2, power_status_init_core3,
    input  power_request_core0, power_request_core1, power_request_core2, power_request_core3,
    input  coherency_unit_idle
  );
endinterface : cppc_if

/* src/cppc_sync.sv */
// two flip-flop synchroniser for a vector of levels
module cppc_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // first stage is only read by the second stage
  always_comb begin
    meta_next = d_in;
    q_next    = meta_reg;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= meta_next;
      q_out    <= q_next;
    end
  end
endmodule : cppc_sync

/* src/cppc_cluster_end.sv */
// cluster end: power status register, request outputs and idle output
module cppc_cluster_end
  import cppc_pkg::*;
#(
  parameter int NUM_CORES   = CPPC_MAX_CORES,
  parameter bit SIMD_PRESENT = 1'b1
) (
  input  wire logic                      mclk_in,
  input  wire logic                      nrst_in,
  cppc_if.cluster                        pins,
  // user side
  input  wire logic                      status_wr_in,
  input  wire logic [CPPC_STATUS_W-1:0]  status_wdata_in,
  input  wire logic                      coh_busy_in,
  input  wire logic [CPPC_MAX_CORES-1:0] core_resting_in,
  output logic      [CPPC_STATUS_W-1:0]  status_out,
  output logic      [CPPC_MAX_CORES-1:0] iface_clamped_out,
  output logic      [CPPC_MAX_CORES-1:0] ram_clamped_out,
  output logic                           coh_ram_clamped_out,
  output logic      [CPPC_MAX_CORES-1:0] simd_clamped_out
);
  //----------------------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------------------
  // every clamp level shares one synchroniser; the slice positions below
  // must follow the order of the concatenation at d_in
  localparam int CW       = 3 * CPPC_MAX_CORES + 1;
  localparam int IW       = CPPC_MAX_CORES * CPPC_FIELD_W;
  localparam int IFC_LSB  = 0;
  localparam int RAM_LSB  = CPPC_MAX_CORES;
  localparam int SIMD_LSB = 2 * CPPC_MAX_CORES;
  localparam int COH_BIT  = CW - 1;

  logic [CW-1:0] clamp_sync;
  logic [IW-1:0] init_sync;

  cppc_sync #(.W(CW)) u_clamp_sync (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .d_in    ({pins.coherency_ram_clamp, pins.simd_logic_clamp, pins.core_ram_clamp,
                pins.interrupt_iface_clamp}),
    .q_out   (clamp_sync)
  );
  // init straps are levels held by the controller, so a plain two-stage path
  // is enough; a strap that moves inside the load window may land half old
  cppc_sync #(.W(IW)) u_init_sync (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .d_in    ({pins.power_status_init_core3, pins.power_status_init_core2,
                pins.power_status_init_core1, pins.power_status_init_core0}),
    .q_out   (init_sync)
  );

  //----------------------------------------------------------------------------
  // init load sequencer
  //----------------------------------------------------------------------------
  // async reset takes constants only, so the straps load on the edges after
  // release; they need two of them to cross the synchroniser, hence three loads
  typedef enum logic [3:0] {
    CPPC_LD_FIRST  = 4'b0001,
    CPPC_LD_SECOND = 4'b0010,
    CPPC_LD_LAST   = 4'b0100,
    CPPC_LD_RUN    = 4'b1000
  } cppc_load_e;

  cppc_load_e load_reg;
  cppc_load_e load_next;
  logic       loading;

  // fields of present cores follow the straps in every state but CPPC_LD_RUN
  always_comb begin
    load_next = load_reg;
    loading   = 1'b1;
    case (load_reg)
      CPPC_LD_FIRST: begin
        load_next = CPPC_LD_SECOND;
      end
      CPPC_LD_SECOND: begin
        load_next = CPPC_LD_LAST;
      end
      CPPC_LD_LAST: begin
        load_next = CPPC_LD_RUN;
      end
      CPPC_LD_RUN: begin
        loading = 1'b0;
      end
      default: begin
        // a broken code restarts the load rather than run on stale fields
        load_next = CPPC_LD_FIRST;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      load_reg <= CPPC_LD_FIRST;
    end else begin
      load_reg <= load_next;
    end
  end

  //----------------------------------------------------------------------------
  // per-core power status field and request output
  //----------------------------------------------------------------------------
  // one field and one request register per core; the request lags the field
  // by one edge so that every pin comes straight from a flip-flop
  logic [CPPC_FIELD_W-1:0]   field_reg [CPPC_MAX_CORES];
  logic [CPPC_FIELD_W-1:0]   req_reg   [CPPC_MAX_CORES];
  logic [CPPC_MAX_CORES-1:0] present;
  logic [CPPC_MAX_CORES-1:0] resting;

  generate
    for (genvar g = 0; g < CPPC_MAX_CORES; g++) begin : g_core
      localparam bit PRESENT = (g < NUM_CORES);
      logic [CPPC_FIELD_W-1:0] field_next;
      logic [CPPC_FIELD_W-1:0] req_next;

      // load from the straps first, then take software writes
      always_comb begin
        field_next = field_reg[g];
        if (!PRESENT) begin
          // absent cores keep a zero field: a powered-on request on a dead pin
          field_next = CPPC_REQ_ON;
        end else if (loading) begin
          field_next = init_sync[g*CPPC_FIELD_W +: CPPC_FIELD_W];
        end else if (status_wr_in) begin
          // writes during the load would be lost under the straps anyway
          field_next = status_wdata_in[g*CPPC_FIELD_STRIDE +: CPPC_FIELD_W];
        end
        req_next = field_reg[g];
      end

      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          field_reg[g] <= CPPC_REQ_ON;
          req_reg[g]   <= CPPC_REQ_ON;
        end else begin
          field_reg[g] <= field_next;
          req_reg[g]   <= req_next;
        end
      end

      assign present[g] = PRESENT;
      // a dormant or off request counts as resting even without standby
      assign resting[g] = !PRESENT || core_resting_in[g]
                          || field_reg[g][CPPC_REQ_OFF_BIT];
    end
  endgenerate

  // status word view: fields at their strides, all other bits read zero
  logic [CPPC_STATUS_W-1:0] status_word;

  always_comb begin
    status_word = CPPC_ZERO_WORD;
    for (int i = 0; i < CPPC_MAX_CORES; i++) begin
      status_word[i*CPPC_FIELD_STRIDE +: CPPC_FIELD_W] = field_reg[i];
    end
  end

  //----------------------------------------------------------------------------
  // idle output and user-side views
  //----------------------------------------------------------------------------
  logic                      idle_reg;
  logic                      idle_next;
  logic [CPPC_MAX_CORES-1:0] iface_next;
  logic [CPPC_MAX_CORES-1:0] ram_next;
  logic                      coh_next;
  logic [CPPC_MAX_CORES-1:0] simd_next;

  // idle stays low through the load so that the l2 clock is never stopped
  // on request fields that are still settling
  always_comb begin
    idle_next  = !coh_busy_in && (&resting) && !loading;
    iface_next = clamp_sync[IFC_LSB +: CPPC_MAX_CORES] & present;
    ram_next   = clamp_sync[RAM_LSB +: CPPC_MAX_CORES] & present;
    coh_next   = clamp_sync[COH_BIT];
    if (SIMD_PRESENT) begin
      simd_next = clamp_sync[SIMD_LSB +: CPPC_MAX_CORES] & present;
    end else begin
      // without the media extension there is no simd logic to clamp
      simd_next = '0;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_reg            <= 1'b0;
      status_out          <= CPPC_ZERO_WORD;
      iface_clamped_out   <= '0;
      ram_clamped_out     <= '0;
      coh_ram_clamped_out <= 1'b0;
      simd_clamped_out    <= '0;
    end else begin
      idle_reg            <= idle_next;
      status_out          <= status_word;
      iface_clamped_out   <= iface_next;
      ram_clamped_out     <= ram_next;
      coh_ram_clamped_out <= coh_next;
      simd_clamped_out    <= simd_next;
    end
  end

  // pins toward the controller, each straight from its register
  assign pins.power_request_core0 = req_reg[0];
  assign pins.power_request_core1 = req_reg[1];
  assign pins.power_request_core2 = req_reg[2];
  assign pins.power_request_core3 = req_reg[3];
  assign pins.coherency_unit_idle = idle_reg;
endmodule : cppc_cluster_end

/* src/cppc_ctrl_end.sv */
// external power controller end with apb registers
module cppc_ctrl_end
  import cppc_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  cppc_if.controller       pins,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             l2_clock_halt_out
);
  //----------------------------------------------------------------------------
  // synchronise cluster outputs
  //----------------------------------------------------------------------------
  logic [8:0] req_sync;

  cppc_sync #(.W(9)) u_req_sync (
    .mclk_in (mclk_in),
    .nrst_in (nrst_in),
    .d_in    ({pins.coherency_unit_idle, pins.power_request_core3, pins.power_request_core2,
                pins.power_request_core1, pins.power_request_core0}),
    .q_out   (req_sync)
  );

  //----------------------------------------------------------------------------
  // registers and apb slave
  //----------------------------------------------------------------------------
  logic [31:0] ctrl_reg, ctrl_next, init_reg, init_next;
  logic [31:0] rdata_next;
  logic        err_next, acc, wr_take;
  logic        halt_next;
  logic        ready_next;
  logic        slverr_next;

  // two-edge access: pready rises after the first access-phase edge, and a
  // write lands only on the edge at which the master sees pready high
  always_comb begin
    acc        = psel_in && penable_in;
    wr_take    = acc && pwrite_in && pready_out;
    ctrl_next  = ctrl_reg;
    init_next  = init_reg;
    rdata_next = CPPC_ZERO_WORD;
    err_next   = 1'b0;
    case (paddr_in)
      CPPC_CTRL_OFF: begin
        rdata_next = ctrl_reg;
        if (wr_take) ctrl_next = pwdata_in;
      end
      CPPC_STAT_OFF: begin
        rdata_next[CPPC_STAT_IDLE_BIT] = req_sync[8];
        rdata_next[7:0]                = req_sync[7:0];
        if (acc && pwrite_in) err_next = 1'b1;
      end
      CPPC_INIT_OFF: begin
        rdata_next = init_reg;
        if (wr_take) init_next = {24'h000000, pwdata_in[7:0]};
      end
      default: begin
        err_next = acc;
      end
    endcase
    if (!acc) rdata_next = CPPC_ZERO_WORD;
    // halt the l2 clock while the coherency unit is idle
    halt_next = req_sync[8];
    // pready is high for one edge at a time; a held request sees it again every second edge
    ready_next  = acc && !pready_out;
    slverr_next = err_next && !pready_out;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg          <= CPPC_ZERO_WORD;
      init_reg          <= CPPC_ZERO_WORD;
      prdata_out        <= CPPC_ZERO_WORD;
      pready_out        <= 1'b0;
      pslverr_out       <= 1'b0;
      l2_clock_halt_out <= 1'b0;
    end else begin
      ctrl_reg          <= ctrl_next;
      init_reg          <= init_next;
      prdata_out        <= rdata_next;
      pready_out        <= ready_next;
      pslverr_out       <= slverr_next;
      l2_clock_halt_out <= halt_next;
    end
  end

  //----------------------------------------------------------------------------
  // pins toward the cluster
  //----------------------------------------------------------------------------
  assign pins.interrupt_iface_clamp   = ctrl_reg[CPPC_CTRL_IFC_LSB +: CPPC_MAX_CORES];
  assign pins.core_ram_clamp          = ctrl_reg[CPPC_CTRL_RAM_LSB +: CPPC_MAX_CORES];
  assign pins.coherency_ram_clamp     = ctrl_reg[CPPC_CTRL_COH_BIT];
  assign pins.simd_logic_clamp        = ctrl_reg[CPPC_CTRL_SIMD_LSB +: CPPC_MAX_CORES];
  assign pins.power_status_init_core0 = init_reg[1:0];
  assign pins.power_status_init_core1 = init_reg[3:2];
  assign pins.power_status_init_core2 = init_reg[5:4];
  assign pins.power_status_init_core3 = init_reg[7:6];
endmodule : cppc_ctrl_end

/* tb/cppc_properties.sv */
// concurrent checks on the pin bundle between cluster and power controller
module cppc_properties (
  input wire logic       mclk_in,
  input wire logic       nrst_in,
  input wire logic [1:0] power_status_init_core0,
  input wire logic [1:0] power_status_init_core1,
  input wire logic [1:0] power_status_init_core2,
  input wire logic [1:0] power_status_init_core3,
  input wire logic [1:0] power_request_core0,
  input wire logic [1:0] power_request_core1,
  input wire logic [1:0] power_request_core2,
  input wire logic [1:0] power_request_core3,
  input wire logic       coherency_unit_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] age_reg;
  logic [3:0] age_next;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  // age since release, saturating so that late init changes are told apart
  always_comb begin
    age_next = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
  end
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) age_reg <= 4'h0;
    else age_reg <= age_next;
  end
  //----------------------------------------------------------------------------
  // properties
  //----------------------------------------------------------------------------
  chk_init_c0: assert property (
    $rose(nrst_in) |-> ##8 (power_request_core0 == power_status_init_core0) [*4])
    else $error("core0 request not loaded from init pins");
  chk_init_c1: assert property (
    $rose(nrst_in) |-> ##8 (power_request_core1 == power_status_init_core1) [*4])
    else $error("core1 request not loaded from init pins");
  chk_init_c2: assert property (
    $rose(nrst_in) |-> ##8 (power_request_core2 == power_status_init_core2) [*4])
    else $error("core2 request not loaded from init pins");
  chk_init_c3: assert property (
    $rose(nrst_in) |-> ##8 (power_request_core3 == power_status_init_core3) [*4])
    else $error("core3 request not loaded from init pins");
  chk_reset_req_on: assert property (
    $rose(nrst_in) |-> (power_request_core0 | power_request_core1 | power_request_core2 | power_request_core3) == 2'h0)
    else $error("request not on while in reset");
  chk_idle_load_low: assert property (
    $rose(nrst_in) |-> !coherency_unit_idle [*3])
    else $error("idle raised during init loading");
  chk_late_init_c0: assert property (
    age_reg == 4'hf && $changed(power_status_init_core0) |=> $stable(power_request_core0) [*3])
    else $error("core0 request followed init pins after loading");
  chk_late_init_c2: assert property (
    age_reg == 4'hf && $changed(power_status_init_core2) |=> $stable(power_request_core2) [*3])
    else $error("core2 request followed init pins after loading");
endmodule : cppc_properties

/* tb/test_cluster_power_control_port.sv */
// testbench joining cluster end and controller end across the pin bundle
module test_cluster_power_control_port
  import cppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in, nrst_in, clu_nrst, psel, penable, pwrite, wr_req, busy, pready, pslverr, halt, coh_c;
  logic [11:0] paddr;
  logic [31:0] pwdata, wdata, prdata, status;
  logic [3:0]  resting, ifc_c, ram_c, simd_c;
  int          miscompares, num_checks, cycles;
  cppc_if      pins ();
  cppc_cluster_end cppc_cluster_end_inst (.mclk_in(mclk_in), .nrst_in(clu_nrst), .pins(pins.cluster),
    .status_wr_in(wr_req), .status_wdata_in(wdata), .coh_busy_in(busy), .core_resting_in(resting),
    .status_out(status), .iface_clamped_out(ifc_c), .ram_clamped_out(ram_c), .coh_ram_clamped_out(coh_c),
    .simd_clamped_out(simd_c));
  cppc_ctrl_end cppc_ctrl_end_inst (.mclk_in(mclk_in), .nrst_in(nrst_in), .pins(pins.controller),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .l2_clock_halt_out(halt));
  cppc_properties cppc_properties_inst (.mclk_in(mclk_in), .nrst_in(clu_nrst),
    .power_status_init_core0(pins.power_status_init_core0), .power_status_init_core1(pins.power_status_init_core1),
    .power_status_init_core2(pins.power_status_init_core2), .power_status_init_core3(pins.power_status_init_core3),
    .power_request_core0(pins.power_request_core0), .power_request_core1(pins.power_request_core1),
    .power_request_core2(pins.power_request_core2), .power_request_core3(pins.power_request_core3),
    .coherency_unit_idle(pins.coherency_unit_idle));
  //----------------------------------------------------------------------------
  // clock, watchdog and shared tasks
  //----------------------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // whole run needs well under a thousand cycles
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_flag(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_flag
  // one apb transfer; waits for pready without assuming its latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_in);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    check_flag(err, exp_err);
  endtask : reg_wr
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, CPPC_ZERO_WORD, rd, err);
    check_word(rd, exp);
    check_flag(err, exp_err);
  endtask : reg_rd
  // status write pulse, then room for request, idle and halt to settle
  task automatic status_wr(input logic [31:0] d);
    @(posedge mclk_in);
    wr_req <= 1'b1;
    wdata <= d;
    @(posedge mclk_in);
    wr_req <= 1'b0;
    repeat (10) @(posedge mclk_in);
  endtask : status_wr
  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    {nrst_in, clu_nrst, psel, penable, pwrite, wr_req, busy, paddr, pwdata, wdata, resting} = '0;
    busy = 1'b1;
    cycles = 0;
    repeat (8) @(posedge mclk_in);
    nrst_in <= 1'b1;
    clu_nrst <= 1'b1;
    repeat (10) @(posedge mclk_in);
    reg_rd(CPPC_CTRL_OFF, CPPC_ZERO_WORD, 1'b0);
    reg_rd(CPPC_INIT_OFF, CPPC_ZERO_WORD, 1'b0);
    reg_rd(12'h00c, CPPC_ZERO_WORD, 1'b1);
    reg_wr(CPPC_STAT_OFF, 32'hffff_ffff, 1'b1);
    reg_rd(CPPC_STAT_OFF, CPPC_ZERO_WORD, 1'b0);
    // distinct init values, then a cluster-only reset loads them
    reg_wr(CPPC_INIT_OFF, 32'h0000_001b, 1'b0);
    repeat (8) @(posedge mclk_in);
    clu_nrst <= 1'b0;
    repeat (8) @(posedge mclk_in);
    clu_nrst <= 1'b1;
    repeat (16) @(posedge mclk_in);
    check_word(status, 32'h0001_0203);
    reg_rd(CPPC_STAT_OFF, 32'h0000_001b, 1'b0);
    // every request code on all cores; idle follows only the b1x codes
    busy <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      status_wr({4{6'h0, v[1:0]}});
      check_word(status, {4{6'h0, v[1:0]}});
      reg_rd(CPPC_STAT_OFF, {15'h0, v[1], 8'h0, {4{v[1:0]}}}, 1'b0);
      check_flag(halt, v[1]);
    end
    status_wr(CPPC_ZERO_WORD);
    resting <= 4'hf;
    repeat (8) @(posedge mclk_in);
    check_flag(halt, 1'b1);
    resting <= 4'h7;
    repeat (8) @(posedge mclk_in);
    check_flag(halt, 1'b0);
    resting <= 4'hf;
    busy <= 1'b1;
    repeat (8) @(posedge mclk_in);
    check_flag(halt, 1'b0);
    // two complementary clamp patterns, so every clamp sees both levels
    for (int i = 0; i < 2; i++) begin
      logic [31:0] c;
      c = (i == 0) ? 32'h0000_1a5c : 32'h0000_05a3;
      reg_wr(CPPC_CTRL_OFF, c, 1'b0);
      repeat (6) @(posedge mclk_in);
      reg_rd(CPPC_CTRL_OFF, c, 1'b0);
      check_word({19'h0, coh_c, simd_c, ram_c, ifc_c}, c);
      check_word({28'h0, pins.interrupt_iface_clamp}, {28'h0, c[3:0]});
    end
    // cluster-only reset while already quiet: idle must wait for the load
    busy <= 1'b0;
    clu_nrst <= 1'b0;
    repeat (8) @(posedge mclk_in);
    clu_nrst <= 1'b1;
    repeat (16) @(posedge mclk_in);
    check_word(status, 32'h0001_0203);
    check_flag(halt, 1'b1);
    complete_run();
  end
endmodule : test_cluster_power_control_port
